// ==== ppf_pkg.sv ====
// Constants for the parallel-port floppy pin multiplexer
package ppf_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int AW = 4;
  localparam int DW = 8;

  localparam logic [3:0] OFS_PDATA = 4'h0;   // Parallel data
  localparam logic [3:0] OFS_PSTAT = 4'h1;   // Parallel status
  localparam logic [3:0] OFS_PCTRL = 4'h2;   // Parallel control
  localparam logic [3:0] OFS_CFG4  = 4'h4;   // Configuration register 4
  localparam logic [3:0] OFS_DSEL  = 4'h5;   // Drive select / motors
  localparam logic [3:0] OFS_PSET  = 4'h6;   // Port settings

  localparam logic [7:0] RST_PDATA = 8'h00;
  localparam logic [7:0] RST_PCTRL = 8'h04;
  localparam logic [7:0] RST_CFG4  = 8'h00;
  localparam logic [7:0] RST_DSEL  = 8'h00;
  localparam logic [7:0] RST_PSET  = 8'h00;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int CFG4_MODE_LSB = 0;   // Two-bit mode field
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PPF1   = 2'h1;   // Drive 1 on connector
  localparam logic [1:0] MODE_PPF2   = 2'h2;   // Drives 0 and 1

  localparam int DSEL_SEL_LSB = 0;    // Two-bit selected drive
  localparam int DSEL_MTR_LSB = 4;    // Four motor enables

  localparam int PSET_ECP = 0;
  localparam int PSET_DMA = 1;

  // Control register bits; STB to SLIN also index the control pin group
  localparam int CTL_STB   = 0;
  localparam int CTL_AFD   = 1;
  localparam int CTL_INIT  = 2;
  localparam int CTL_SLIN  = 3;
  localparam int CTL_IRQEN = 4;
  localparam int CTL_DIR   = 5;

  // Status pin group index
  localparam int STS_ACK   = 0;
  localparam int STS_BUSY  = 1;
  localparam int STS_PE    = 2;
  localparam int STS_PRINTER_SELECTED  = 3;
  localparam int STS_FAULT = 4;

  // Status register bit positions
  localparam int SR_PORT_BUSY_STATUS = 7;
  localparam int SR_PORT_ACKNOWLEDGE  = 6;
  localparam int SR_PE    = 5;
  localparam int SR_PRINTER_SELECTED  = 4;
  localparam int SR_PORT_FAULT  = 3;

  // Fixed "cable not connected" answers in floppy mode
  localparam logic [7:0] PSTAT_FLOPPY  = 8'h48;
  localparam logic [3:0] PCTRL_FLOPPY  = 4'h4;

  // Dedicated floppy output vector index
  localparam int FO_WDATA = 0;
  localparam int FO_DENS  = 1;
  localparam int FO_HEAD  = 2;
  localparam int FO_WGATE = 3;
  localparam int FO_DIR   = 4;
  localparam int FO_STEP  = 5;
  localparam int FO_DS0   = 6;
  localparam int FO_DS1   = 7;
  localparam int FO_MTR0  = 8;
  localparam int FO_MTR1  = 9;

  // Floppy input vector index
  localparam int FI_INDEX  = 0;
  localparam int FI_TRK0   = 1;
  localparam int FI_WP     = 2;
  localparam int FI_RDATA  = 3;
  localparam int FI_DSKCHG = 4;
  localparam int FI_MID0   = 5;
  localparam int FI_MID1   = 6;

  localparam int SYNC_W = 25;   // Pin inputs through the synchroniser

endpackage

// ==== ppf_sync.sv ====
// Two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module ppf_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_q
);
  logic [W-1:0] meta_q;

  // First stage is read by the second stage only
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule // ppf_sync

// ==== ppf_mux.sv ====
// Parallel-port floppy pin multiplexer with its register port
`timescale 1ns/1ps
module ppf_mux
  import ppf_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst,
  // Register port
  input  wire logic [ppf_pkg::AW-1:0] reg_addr,
  input  wire logic [ppf_pkg::DW-1:0] reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [ppf_pkg::DW-1:0] reg_rdata,
  // Floppy core, same clock
  input  wire logic          core_wdata_n,
  input  wire logic          core_density,
  input  wire logic          core_head_n,
  input  wire logic          core_wgate_n,
  input  wire logic          core_dir_n,
  input  wire logic          core_step_n,
  input  wire logic          core_dma_req,
  output logic [6:0]         core_disk_status,
  output logic               core_addr10,
  // Dedicated floppy pins
  input  wire logic [6:0]    flp_in_pins,
  output logic [9:0]         flp_out_drv,
  output logic [9:0]         flp_out_en,
  // Parallel connector pins
  input  wire logic [7:0]    port_data_pins,
  output logic [7:0]         port_data_drv,
  output logic [7:0]         port_data_en,
  input  wire logic [3:0]    port_ctl_pins,
  output logic [3:0]         port_ctl_drv,
  output logic [3:0]         port_ctl_en,
  input  wire logic [4:0]    port_sts_pins,
  output logic [4:0]         port_sts_drv,
  output logic [4:0]         port_sts_en,
  // Shared pins
  output logic               drive2_sel_or_port_dir_drv,
  output logic               drive2_sel_or_port_dir_en,
  input  wire logic          addr10_or_drive3_sel_pin,
  output logic               addr10_or_drive3_sel_drv,
  output logic               addr10_or_drive3_sel_en,
  output logic               motor2_or_port_dma_ack_drv,
  output logic               motor2_or_port_dma_ack_en,
  output logic               motor3_or_port_dma_req_drv,
  output logic               motor3_or_port_dma_req_en,
  output logic               port_interrupt_out_drv,
  output logic               port_interrupt_out_en
);
  import ppf_pkg::*;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Active-low select for drive n
  function automatic logic sel_n(input logic [1:0] sel,
                                 input logic [1:0] n);
    sel_n = (sel != n);
  endfunction

  // Drive routed to the connector in the given mode
  function automatic logic on_port(input logic [1:0] mode,
                                   input logic [1:0] drv);
    on_port = ((mode == MODE_PPF1) && (drv == 2'd1)) ||
              ((mode == MODE_PPF2) && (drv <= 2'd1));
  endfunction

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  logic [7:0] pdata_q, pctrl_q, cfg4_q, dsel_q, pset_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_val;

  logic [1:0] mode;
  logic       floppy;
  logic       dual;
  logic       ecp;
  logic       dma_en;
  logic [1:0] sel;
  logic [3:0] mtr;
  logic       routed;

  assign mode   = cfg4_q[CFG4_MODE_LSB +: 2];
  assign floppy = (mode == MODE_PPF1) || (mode == MODE_PPF2);
  assign dual   = (mode == MODE_PPF2);
  assign ecp    = pset_q[PSET_ECP];
  assign dma_en = pset_q[PSET_DMA];
  assign sel    = dsel_q[DSEL_SEL_LSB +: 2];
  assign mtr    = dsel_q[DSEL_MTR_LSB +: 4];
  assign routed = on_port(mode, sel);

  // Writes store even in floppy mode so data reads back
  always_ff @(posedge clock) begin
    if (rst) begin
      pdata_q <= RST_PDATA;
      pctrl_q <= RST_PCTRL;
      cfg4_q  <= RST_CFG4;
      dsel_q  <= RST_DSEL;
      pset_q  <= RST_PSET;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_PDATA: pdata_q <= reg_wdata;
        OFS_PCTRL: pctrl_q <= reg_wdata;
        OFS_CFG4:  cfg4_q  <= reg_wdata;
        OFS_DSEL:  dsel_q  <= reg_wdata;
        OFS_PSET:  pset_q  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Pin input synchronisers
  // --------------------------------------------------------------
  logic [SYNC_W-1:0] sync_v;
  logic [7:0]        pd_s;
  logic [3:0]        ctl_s;
  logic [4:0]        sts_s;
  logic              a10_s;
  logic [6:0]        flp_s;

  ppf_sync #(.W(SYNC_W)) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({flp_in_pins, addr10_or_drive3_sel_pin, port_sts_pins,
                port_ctl_pins, port_data_pins}),
    .sync_q   (sync_v)
  );

  assign pd_s  = sync_v[7:0];
  assign ctl_s = sync_v[11:8];
  assign sts_s = sync_v[16:12];
  assign a10_s = sync_v[17];
  assign flp_s = sync_v[24:18];

  // --------------------------------------------------------------
  // Register reads; data stand for the one cycle after the strobe
  // --------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    case (reg_addr)
      OFS_PDATA: rd_val = floppy ? pdata_q : pd_s;
      OFS_PSTAT: begin
        if (floppy) begin
          rd_val = PSTAT_FLOPPY;
        end else begin
          rd_val[SR_PORT_BUSY_STATUS] = ~sts_s[STS_BUSY];
          rd_val[SR_PORT_ACKNOWLEDGE]  = sts_s[STS_ACK];
          rd_val[SR_PE]    = sts_s[STS_PE];
          rd_val[SR_PRINTER_SELECTED]  = sts_s[STS_PRINTER_SELECTED];
          rd_val[SR_PORT_FAULT]  = sts_s[STS_FAULT];
        end
      end
      OFS_PCTRL: rd_val = floppy ? {pctrl_q[7:4], PCTRL_FLOPPY}
                                 : pctrl_q;
      OFS_CFG4:  rd_val = cfg4_q;
      OFS_DSEL:  rd_val = dsel_q;
      OFS_PSET:  rd_val = pset_q;
      default:   rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_val : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // --------------------------------------------------------------
  // Floppy status toward the core
  // --------------------------------------------------------------
  logic [6:0] disk_d, disk_q;
  logic       a10_q;

  always_comb begin
    if (floppy && routed) begin
      disk_d[FI_INDEX]  = pd_s[0];
      disk_d[FI_TRK0]   = pd_s[1];
      disk_d[FI_WP]     = pd_s[2];
      disk_d[FI_RDATA]  = pd_s[3];
      disk_d[FI_DSKCHG] = pd_s[4];
      disk_d[FI_MID0]   = pd_s[5];
      disk_d[FI_MID1]   = pd_s[7];
    end else begin
      disk_d = flp_s;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      disk_q <= 7'h7F;
      a10_q  <= 1'b0;
    end else begin
      disk_q <= disk_d;
      a10_q  <= a10_s;
    end
  end

  assign core_disk_status = disk_q;
  assign core_addr10      = a10_q;

  // --------------------------------------------------------------
  // Pin drive and direction, all from registered state
  // --------------------------------------------------------------
  logic [9:0] fo_d, foe_d, fo_q, foe_q;
  logic [7:0] pd_d, pde_d, pd_q, pde_q;
  logic [3:0] cd_d, cde_d, cd_q, cde_q;
  logic [4:0] sd_d, sde_d, sd_q, sde_q;
  logic [4:0] sh_d, she_d, sh_q, she_q;   // d2, a10, m2, m3, irq

  always_comb begin
    // Dedicated floppy outputs
    fo_d[FO_WDATA] = core_wdata_n;
    fo_d[FO_DENS]  = core_density;
    fo_d[FO_HEAD]  = core_head_n;
    fo_d[FO_WGATE] = core_wgate_n;
    fo_d[FO_DIR]   = core_dir_n;
    fo_d[FO_STEP]  = core_step_n;
    fo_d[FO_DS0]   = dual | sel_n(sel, 2'd0);
    fo_d[FO_DS1]   = floppy | sel_n(sel, 2'd1);
    fo_d[FO_MTR0]  = dual | ~mtr[0];
    fo_d[FO_MTR1]  = floppy | ~mtr[1];
    foe_d = (floppy && routed) ? 10'h000 : 10'h3FF;

    // Normal port: data direction from control, control pins driven
    pd_d  = pdata_q;
    pde_d = pctrl_q[CTL_DIR] ? 8'h00 : 8'hFF;
    cd_d[CTL_STB]  = ~pctrl_q[CTL_STB];
    cd_d[CTL_AFD]  = ~pctrl_q[CTL_AFD];
    cd_d[CTL_INIT] = pctrl_q[CTL_INIT];
    cd_d[CTL_SLIN] = ~pctrl_q[CTL_SLIN];
    cde_d = 4'hF;
    sd_d  = 5'h00;
    sde_d = 5'h00;

    // Shared pins in normal mode
    if (ecp) begin
      sh_d  = {~sts_s[STS_ACK], core_dma_req & dma_en, 1'b1, 1'b1,
               pctrl_q[CTL_DIR]};
      she_d = {pctrl_q[CTL_IRQEN], 1'b1, 1'b0, 1'b0, 1'b1};
    end else begin
      sh_d  = {~sts_s[STS_ACK], ~mtr[3], ~mtr[2], sel_n(sel, 2'd3),
               sel_n(sel, 2'd2)};
      she_d = {pctrl_q[CTL_IRQEN], 4'hF};
    end

    if (floppy) begin
      // Data pins are inputs except data 6 in dual mode
      pd_d     = 8'h00;
      pd_d[6]  = ~mtr[0];
      pde_d    = {1'b0, dual, 6'h00};
      cd_d[CTL_STB]  = sel_n(sel, 2'd0);
      cd_d[CTL_AFD]  = core_density;
      cd_d[CTL_INIT] = core_dir_n;
      cd_d[CTL_SLIN] = core_step_n;
      cde_d = {3'h7, dual};
      sd_d[STS_ACK]   = sel_n(sel, 2'd1);
      sd_d[STS_BUSY]  = ~mtr[1];
      sd_d[STS_PE]    = core_wdata_n;
      sd_d[STS_PRINTER_SELECTED]  = core_wgate_n;
      sd_d[STS_FAULT] = core_head_n;
      sde_d = 5'h1F;
      // Shared pins: d2 high under ECP, others float or low
      sh_d  = 5'h01;
      she_d = {pctrl_q[CTL_IRQEN],
               ecp & dma_en,
               1'b0, 1'b0,
               ecp};
    end
  end

  // Registered so a mode or select change never glitches a pin
  always_ff @(posedge clock) begin
    if (rst) begin
      fo_q  <= 10'h3FF;
      foe_q <= 10'h000;
      pd_q  <= 8'h00;
      pde_q <= 8'h00;
      cd_q  <= 4'h0;
      cde_q <= 4'h0;
      sd_q  <= 5'h00;
      sde_q <= 5'h00;
      sh_q  <= 5'h00;
      she_q <= 5'h00;
    end else begin
      fo_q  <= fo_d;
      foe_q <= foe_d;
      pd_q  <= pd_d;
      pde_q <= pde_d;
      cd_q  <= cd_d;
      cde_q <= cde_d;
      sd_q  <= sd_d;
      sde_q <= sde_d;
      sh_q  <= sh_d;
      she_q <= she_d;
    end
  end

  assign flp_out_drv   = fo_q;
  assign flp_out_en    = foe_q;
  assign port_data_drv = pd_q;
  assign port_data_en  = pde_q;
  assign port_ctl_drv  = cd_q;
  assign port_ctl_en   = cde_q;
  assign port_sts_drv  = sd_q;
  assign port_sts_en   = sde_q;

  assign drive2_sel_or_port_dir_drv = sh_q[0];
  assign drive2_sel_or_port_dir_en  = she_q[0];
  assign addr10_or_drive3_sel_drv   = sh_q[1];
  assign addr10_or_drive3_sel_en    = she_q[1];
  assign motor2_or_port_dma_ack_drv = sh_q[2];
  assign motor2_or_port_dma_ack_en  = she_q[2];
  assign motor3_or_port_dma_req_drv = sh_q[3];
  assign motor3_or_port_dma_req_en  = she_q[3];
  assign port_interrupt_out_drv     = sh_q[4];
  assign port_interrupt_out_en      = she_q[4];

endmodule // ppf_mux

// ==== ppf_mux_sva.sv ====
// Checker for the parallel-port floppy pin multiplexer
`timescale 1ns/1ps
module ppf_mux_sva
  import ppf_pkg::*;
(
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic [ppf_pkg::AW-1:0] reg_addr,
  input wire logic [ppf_pkg::DW-1:0] reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [ppf_pkg::DW-1:0] reg_rdata,
  input wire logic [9:0]             flp_out_en,
  input wire logic [7:0]             port_data_en,
  input wire logic [3:0]             port_ctl_en,
  input wire logic [4:0]             port_sts_en,
  input wire logic                   drive2_sel_or_port_dir_drv,
  input wire logic                   drive2_sel_or_port_dir_en,
  input wire logic                   addr10_or_drive3_sel_en,
  input wire logic                   motor2_or_port_dma_ack_en,
  input wire logic                   motor3_or_port_dma_req_drv,
  input wire logic                   motor3_or_port_dma_req_en,
  input wire logic                   port_interrupt_out_drv,
  input wire logic                   port_interrupt_out_en
);
  // ----------------------------------------------------------------
  // Shadow of the mode registers
  // ----------------------------------------------------------------
  logic [1:0] mode_q, sel_q;
  logic       ecp_q, dma_q, live_q, fl, on_conn;

  assign fl = (mode_q == MODE_PPF1) || (mode_q == MODE_PPF2);
  assign on_conn = (mode_q == MODE_PPF1) ? (sel_q == 2'h1)
                 : (mode_q == MODE_PPF2) && (sel_q <= 2'h1);

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= 2'h0;
      sel_q  <= 2'h0;
      ecp_q  <= 1'b0;
      dma_q  <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CFG4) mode_q <= reg_wdata[1:0];
      if (reg_addr == OFS_DSEL) sel_q <= reg_wdata[1:0];
      if (reg_addr == OFS_PSET) ecp_q <= reg_wdata[PSET_ECP];
      if (reg_addr == OFS_PSET) dma_q <= reg_wdata[PSET_DMA];
    end
  end

  // Pins lag the registers by one edge; skip the load edge
  always_ff @(posedge clock) begin
    live_q <= !rst;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_fl_rd(logic [3:0] ofs);
    reg_rd && reg_addr == ofs && fl;
  endsequence
  sequence s_fl_pins;
    live_q && $past(fl);
  endsequence

  a_dir_pin_ecp: assert property (s_fl_pins |->
    drive2_sel_or_port_dir_en == $past(ecp_q) &&
    (!$past(ecp_q) || drive2_sel_or_port_dir_drv))
    else $error("direction pin wrong in floppy mode");
  a_addr10_float: assert property (s_fl_pins |->
    !addr10_or_drive3_sel_en && !motor2_or_port_dma_ack_en)
    else $error("address or dma ack pin driven in floppy mode");
  a_dma_req_low: assert property (s_fl_pins |->
    motor3_or_port_dma_req_en == ($past(ecp_q) && $past(dma_q)) &&
    !(motor3_or_port_dma_req_en && motor3_or_port_dma_req_drv))
    else $error("dma request pin wrong in floppy mode");
  a_irq_silent: assert property (s_fl_pins |->
    !(port_interrupt_out_en && port_interrupt_out_drv))
    else $error("port interrupt active in floppy mode");
  a_flp_outs_float: assert property (live_q && $past(on_conn) |->
    flp_out_en == 10'h000)
    else $error("floppy outputs driven while drive on connector");
  a_strobe_dual: assert property (
    live_q && $past(mode_q) == MODE_PPF2 |->
    port_ctl_en[CTL_STB] && port_data_en[6])
    else $error("strobe or data 6 not driven in dual mode");
  a_strobe_single: assert property (
    live_q && $past(mode_q) == MODE_PPF1 |->
    !port_ctl_en[CTL_STB] && !port_data_en[6])
    else $error("strobe or data 6 driven in single mode");
  a_normal_dirs: assert property (live_q && !$past(fl) |->
    port_ctl_en == 4'hF && port_sts_en == 5'h00)
    else $error("port directions wrong in normal mode");
  a_status_read: assert property (s_fl_rd(OFS_PSTAT) |=>
    reg_rdata == PSTAT_FLOPPY)
    else $error("status read wrong in floppy mode");
  a_ctrl_read: assert property (s_fl_rd(OFS_PCTRL) |=>
    reg_rdata[3:0] == PCTRL_FLOPPY)
    else $error("control read wrong in floppy mode");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero without a read");
endmodule // ppf_mux_sva

// ==== ppf_drive.sv ====
// Floppy drive model cabled to the parallel connector
`timescale 1ns/1ps
module ppf_drive (
  input  wire logic       drive_sel_n,
  input  wire logic [6:0] disk_state,
  output logic      [6:0] disk_lines
);
  // Open-collector lines; terminators pull them high when deselected
  assign disk_lines = drive_sel_n ? 7'h7F : disk_state;
endmodule // ppf_drive

// ==== ppf_mux_tb.sv ====
// Self-checking testbench for the floppy pin multiplexer
`timescale 1ns/1ps
module ppf_mux_tb;
  import ppf_pkg::*;
  logic       clock, rst, reg_wr, reg_rd, core_wdata_n, core_density;
  logic       core_head_n, core_wgate_n, core_dir_n, core_step_n;
  logic       core_dma_req, core_addr10, addr10_or_drive3_sel_pin;
  logic [3:0] reg_addr, port_ctl_pins, port_ctl_drv, port_ctl_en;
  logic [7:0] reg_wdata, reg_rdata, port_data_pins, port_data_drv;
  logic [7:0] port_data_en;
  logic [6:0] core_disk_status, flp_in_pins, st, disk_lines;
  logic [9:0] flp_out_drv, flp_out_en;
  logic [4:0] port_sts_pins, port_sts_drv, port_sts_en, sts_ext;
  logic       drive2_sel_or_port_dir_drv, drive2_sel_or_port_dir_en;
  logic       addr10_or_drive3_sel_drv, addr10_or_drive3_sel_en;
  logic       motor2_or_port_dma_ack_drv, motor2_or_port_dma_ack_en;
  logic       motor3_or_port_dma_req_drv, motor3_or_port_dma_req_en;
  logic       port_interrupt_out_drv, port_interrupt_out_en, rd_seen;
  logic [7:0] exp_q[$];
  int         err_count, checks_done;

  // ----------------------------------------------------------------
  // Wire resolution: undriven control lines are pulled high
  // ----------------------------------------------------------------
  assign port_ctl_pins = (port_ctl_en & port_ctl_drv) | ~port_ctl_en;
  assign port_sts_pins = (port_sts_en & port_sts_drv)
                       | (~port_sts_en & sts_ext);
  assign port_data_pins = (port_data_en & port_data_drv)
                        | (~port_data_en &
                           {disk_lines[6], 1'b1, disk_lines[5:0]});

  ppf_drive u_drv (
    .drive_sel_n (port_sts_pins[STS_ACK] & port_ctl_pins[CTL_STB]),
    .disk_state  (st),
    .disk_lines  (disk_lines)
  );

  ppf_mux dut (
    .clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .core_wdata_n, .core_density, .core_head_n, .core_wgate_n,
    .core_dir_n, .core_step_n, .core_dma_req, .core_disk_status,
    .core_addr10, .flp_in_pins, .flp_out_drv, .flp_out_en,
    .port_data_pins, .port_data_drv, .port_data_en, .port_ctl_pins,
    .port_ctl_drv, .port_ctl_en, .port_sts_pins, .port_sts_drv,
    .port_sts_en, .drive2_sel_or_port_dir_drv, .drive2_sel_or_port_dir_en,
    .addr10_or_drive3_sel_pin, .addr10_or_drive3_sel_drv,
    .addr10_or_drive3_sel_en, .motor2_or_port_dma_ack_drv,
    .motor2_or_port_dma_ack_en, .motor3_or_port_dma_req_drv,
    .motor3_or_port_dma_req_en, .port_interrupt_out_drv,
    .port_interrupt_out_en
  );

  always #2 clock = ~clock;

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    chk({2'b00, got}, {2'b00, exp});
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clock) begin
    rd_seen <= reg_rd;
    if (rd_seen === 1'b1)
      chk_rd(reg_rdata, exp_q.pop_front());
  end

  task automatic op(input logic w, input logic r, input logic [3:0] a,
                    input logic [7:0] d);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    if (r) exp_q.push_back(d);
  endtask

  task automatic settle();
    op(1'b0, 1'b0, 4'h0, 8'h00);
    repeat (5) @(posedge clock);
    #1;
  endtask

  task automatic chk_normal();
    sts_ext <= 5'($urandom);
    settle();
    chk({port_ctl_en, port_sts_en}, 9'h1E0);
    chk(port_data_en, 8'hFF);
    op(1'b0, 1'b1, OFS_PSTAT, {~sts_ext[STS_BUSY], sts_ext[STS_ACK],
       sts_ext[STS_PE], sts_ext[STS_PRINTER_SELECTED], sts_ext[STS_FAULT], 3'b000});
  endtask

  task automatic give_verdict();
    $display("errors %0d, checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [3:0] mot;
    logic       on;
    clock = 1'b0;
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {core_wdata_n, core_density, core_head_n, core_wgate_n} = '1;
    {core_dir_n, core_step_n, core_dma_req} = 3'h6;
    {addr10_or_drive3_sel_pin, flp_in_pins, st, sts_ext} = '1;
    err_count = 0;
    checks_done = 0;
    void'($urandom(32'h846d_d5a3));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    op(1'b0, 1'b1, OFS_CFG4, RST_CFG4);
    op(1'b0, 1'b1, OFS_PCTRL, RST_PCTRL);
    op(1'b0, 1'b1, OFS_DSEL, RST_DSEL);
    op(1'b0, 1'b1, OFS_PSET, RST_PSET);
    op(1'b0, 1'b1, 4'hF, 8'h00);
    chk_normal();
    chk({drive2_sel_or_port_dir_en, addr10_or_drive3_sel_drv,
         addr10_or_drive3_sel_en, motor2_or_port_dma_ack_drv,
         motor2_or_port_dma_ack_en, port_interrupt_out_en},
        6'h3E);
    for (int m = 1; m <= 2; m++) begin
      for (int p = 0; p < 4; p++) begin
        d = 8'($urandom);
        mot = 4'($urandom);
        st <= 7'($urandom);
        flp_in_pins <= 7'($urandom);
        addr10_or_drive3_sel_pin <= 1'($urandom);
        {core_wdata_n, core_density, core_head_n, core_wgate_n,
         core_dir_n, core_step_n, core_dma_req} <= 7'($urandom);
        op(1'b1, 1'b0, OFS_CFG4, 8'(m));
        op(1'b1, 1'b0, OFS_PSET, 8'(p));
        op(1'b1, 1'b0, OFS_PDATA, d);
        for (int s = 0; s < 3; s++) begin
          op(1'b1, 1'b0, OFS_DSEL, {mot, 2'b00, 2'(s)});
          settle();
          on = (m == 1) ? (s == 1) : (s <= 1);
          chk(flp_out_en, on ? 10'h000 : 10'h3FF);
          chk(core_disk_status, on ? st : flp_in_pins);
          chk({port_sts_drv, port_ctl_drv[3:1]}, {core_head_n,
              core_wgate_n, core_wdata_n, ~mot[1], 1'(s != 1),
              core_step_n, core_dir_n, core_density});
          chk({port_ctl_en[CTL_STB], port_data_en[6]},
              (m == 2) ? 2'b11 : 2'b00);
          if (m == 2) chk({port_ctl_drv[CTL_STB], port_data_drv[6]},
                          {1'(s != 0), ~mot[0]});
          chk(flp_out_drv, {1'b1, (m == 2) | ~mot[0], 1'b1,
              (m == 2) | (s != 0), core_step_n, core_dir_n, core_wgate_n,
              core_head_n, core_density, core_wdata_n});
        end
        chk(port_sts_en, 5'h1F);
        chk(core_addr10, addr10_or_drive3_sel_pin);
        chk({drive2_sel_or_port_dir_en, motor3_or_port_dma_req_en},
            {1'(p % 2), 1'(p == 3)});
        op(1'b0, 1'b1, OFS_PDATA, d);
        op(1'b0, 1'b1, OFS_PSTAT, PSTAT_FLOPPY);
        op(1'b0, 1'b1, OFS_PCTRL, 8'h04);
      end
    end
    op(1'b1, 1'b0, OFS_CFG4, 8'h03);
    chk_normal();
    chk({addr10_or_drive3_sel_en, motor2_or_port_dma_ack_en}, 2'b00);
    op(1'b1, 1'b0, OFS_CFG4, 8'h00);
    chk_normal();
    settle();
    give_verdict();
  end
endmodule // ppf_mux_tb

bind ppf_mux ppf_mux_sva u_sva (
  .clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .flp_out_en, .port_data_en, .port_ctl_en, .port_sts_en,
  .drive2_sel_or_port_dir_drv, .drive2_sel_or_port_dir_en,
  .addr10_or_drive3_sel_en, .motor2_or_port_dma_ack_en,
  .motor3_or_port_dma_req_drv, .motor3_or_port_dma_req_en,
  .port_interrupt_out_drv, .port_interrupt_out_en
);
